// [rtl/pmsv_pkg.sv]
/*
 * Shared constants of the supervisor: slave addresses, register map, field
 * positions, thermal thresholds, timing counts, state encodings.
 * Assumes a 40 MHz core clock.
 */
package pmsv_pkg;
	// clock
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned CLK_PERIOD_NS = 25;
	// watchdog time and buck off time of a power cycle
	localparam int unsigned WD_TIME_S         = 8;
	localparam int unsigned PWR_CYCLE_TIME_MS = 8;
	localparam int unsigned WD_CYCLES         = WD_TIME_S * CLK_HZ;
	localparam int unsigned PWR_CYCLE_CYCLES  = PWR_CYCLE_TIME_MS * (CLK_HZ / 1000);
	localparam int          CNT_W             = 29;
	// serial bus timing: a quarter of the bus clock period per step
	localparam int unsigned SCL_PERIOD_NS = 2500;
	localparam int unsigned QTR_CYCLES    = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
	// slave addresses of the two portions
	localparam logic [6:0] ADDR_PMIC = 7'h25;
	localparam logic [6:0] ADDR_PLP  = 7'h26;
	// device registers
	localparam logic [7:0] REG_SYS_CTRL = 8'h04;
	localparam logic [7:0] REG_STATUS   = 8'h05;
	localparam logic [7:0] REG_MASK     = 8'h06;
	localparam logic [7:0] REG_KEY      = 8'h0a;
	localparam logic [7:0] KEY_UNLOCK   = 8'haa;
	localparam logic [7:0] RST_SYS_CTRL = 8'h00;
	localparam logic [7:0] RST_MASK     = 8'h00;
	localparam logic [7:0] RST_KEY      = 8'h00;
	// system_power_control fields
	localparam int SYS_MANUAL_CYCLE = 0;
	localparam int SYS_POWER_OFF    = 1;
	localparam int SYS_WD_SOFT_EN   = 2;
	localparam int SYS_WD_CYCLE_EN  = 3;
	// status and mask fields
	localparam int ST_ALERT    = 0;
	localparam int ST_CONV_OFF = 1;
	localparam int ST_ALL_OFF  = 2;
	localparam int ST_WD_EXP   = 3;
	// die temperature thresholds in degrees C
	localparam logic [7:0] TEMP_ALERT    = 8'd120;
	localparam logic [7:0] TEMP_CONV_OFF = 8'd145;
	localparam logic [7:0] TEMP_ALL_OFF  = 8'd155;
	localparam logic [7:0] TEMP_HYST     = 8'd15;
	// controller registers on APB
	localparam logic [7:0] HREG_CMD    = 8'h00;
	localparam logic [7:0] HREG_ADDR   = 8'h04;
	localparam logic [7:0] HREG_WDATA  = 8'h08;
	localparam logic [7:0] HREG_STATUS = 8'h0c;
	localparam logic [7:0] HREG_RDATA  = 8'h10;
	localparam int CMD_GO   = 0;
	localparam int CMD_READ = 1;
	localparam int CMD_PLP  = 2;
	// power sequencer states
	typedef enum logic [2:0] {
		SQ_OFF    = 3'b000,
		SQ_START  = 3'b001,
		SQ_ON     = 3'b010,
		SQ_CYCLE  = 3'b011,
		SQ_PWROFF = 3'b100
	} pmsv_seq_t;
	// bus slave phases
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_ADDR = 3'b001,
		PH_REG  = 3'b010,
		PH_DATA = 3'b011,
		PH_READ = 3'b100
	} pmsv_phase_t;
	// bus master states
	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_START = 2'b01,
		HS_BIT   = 2'b10,
		HS_STOP  = 2'b11
	} pmsv_hstate_t;
endpackage : pmsv_pkg

// [rtl/pmsv_link_if.sv]
/*
 * Two-wire serial link between controller and supervisor.
 * Assumes pull-ups: a line is low only while some end drives it low.
 */
`timescale 1ns/1ps
interface pmsv_link_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;
	// wired-and resolution of the open-drain lines
	assign scl = host_scl_oe_n | host_scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
		output host_sda_o, output host_sda_oe_n);
endinterface : pmsv_link_if

// [rtl/pmsv_device.sv]
/*
 * Supervisor end: serial bus slave at two addresses with write locks,
 * watchdog, power sequencer, thermal protection and interrupt output.
 * Assumes synchronous inputs, a controller that drives the bus clock,
 * and factory straps held steady while RST_I is high.
 */
`timescale 1ns/1ps
module pmsv_device #(
	parameter int unsigned WD_CYCLES        = pmsv_pkg::WD_CYCLES,
	parameter int unsigned PWR_CYCLE_CYCLES = pmsv_pkg::PWR_CYCLE_CYCLES
) (
	// clock and reset
	input  wire logic       CORE_CLK_I,
	input  wire logic       RST_I,
	// factory straps and pin
	input  wire logic       FACTORY_PIN_SUPPLEMENT_I,
	input  wire logic       FACTORY_HARD_RESET_HIGH_I,
	input  wire logic       GENERAL_PIN_FIVE_I,
	// die temperature in degrees C
	input  wire logic [7:0] DIE_TEMP_I,
	// regulator controls
	output logic      [3:0] BUCK_EN_O,
	output logic            LDO_EN_O,
	output logic            BOOST_EN_O,
	output logic            SUPPLEMENT_O,
	output logic            SOFT_START_O,
	output logic            SOFT_RESET_O,
	// interrupt
	output logic            INTERRUPT_OUT_N_O,
	// serial link
	pmsv_link_if.device     LINK
);
	// hysteresis comparator: set above thr, clear at or below thr - hyst
	function automatic logic thermal_next(input logic act, input logic [7:0] t,
		input logic [7:0] thr);
		thermal_next = act ? (t > thr - pmsv_pkg::TEMP_HYST) : (t > thr);
	endfunction : thermal_next

	logic                  pin_supp;
	logic                  hr_high;
	logic                  rst;
	logic                  scl_q, scl_p, sda_q, sda_p;
	logic                  scl_rise, scl_fall, start, stop;
	logic [3:0]            bit_cnt;
	logic [7:0]            shift;
	pmsv_pkg::pmsv_phase_t phase;
	logic                  sel_plp;
	logic                  sda_low;
	logic [7:0]            rd_byte;
	logic [7:0]            ptr_pmic, ptr_plp;
	logic                  byte_done, hit_pmic, hit_plp;
	logic                  wr_stb, rd_stb, rd_clr, kick;
	logic [7:0]            sys_ctrl, mask;
	logic                  unlk_pmic, unlk_plp;
	logic [2:0]            th, next_th;
	logic [3:0]            sticky, status;
	logic                  wd_en, wd_exp;
	logic [pmsv_pkg::CNT_W-1:0] wd_cnt, cyc_cnt;
	logic                  pc_go, sr_go;
	pmsv_pkg::pmsv_seq_t   st;

	// factory straps are caught while the system reset is applied
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			pin_supp <= FACTORY_PIN_SUPPLEMENT_I;
			hr_high  <= FACTORY_HARD_RESET_HIGH_I;
		end
	end

	// internal reset: system reset or active hard-reset pin
	assign rst = RST_I | (!pin_supp && (GENERAL_PIN_FIVE_I == hr_high));

	// bus line edges and conditions
	assign scl_rise  = scl_q & ~scl_p;
	assign scl_fall  = ~scl_q & scl_p;
	assign start     = scl_q & scl_p & sda_p & ~sda_q;
	assign stop      = scl_q & scl_p & ~sda_p & sda_q;
	assign byte_done = scl_fall && bit_cnt == 4'd8;
	assign hit_pmic  = shift[7:1] == pmsv_pkg::ADDR_PMIC;
	assign hit_plp   = shift[7:1] == pmsv_pkg::ADDR_PLP;
	assign wr_stb    = byte_done && phase == pmsv_pkg::PH_DATA;
	assign rd_stb    = byte_done && phase == pmsv_pkg::PH_ADDR && shift[0];
	assign rd_clr    = rd_stb && hit_pmic && ptr_pmic == pmsv_pkg::REG_STATUS;
	assign kick      = byte_done && phase == pmsv_pkg::PH_ADDR && hit_pmic;

	// register read mux of the two portions
	function automatic logic [7:0] read_reg(input logic plp, input logic [7:0] a,
		input logic [7:0] sc, input logic [7:0] mk, input logic [3:0] sts,
		input logic ulp, input logic ulm);
		read_reg = 8'h00;
		if (plp) begin
			if (a == pmsv_pkg::REG_KEY) read_reg = ulp ? pmsv_pkg::KEY_UNLOCK : 8'h00;
		end else begin
			case (a)
				pmsv_pkg::REG_SYS_CTRL: read_reg = sc;
				pmsv_pkg::REG_STATUS:   read_reg = {4'h0, sts};
				pmsv_pkg::REG_MASK:     read_reg = mk;
				pmsv_pkg::REG_KEY:      read_reg = ulm ? pmsv_pkg::KEY_UNLOCK : 8'h00;
				default:                read_reg = 8'h00;
			endcase
		end
	endfunction : read_reg

	// bus slave: address, register pointer, data, read
	always_ff @(posedge CORE_CLK_I) begin
		if (rst) begin
			scl_q    <= 1'b1;
			scl_p    <= 1'b1;
			sda_q    <= 1'b1;
			sda_p    <= 1'b1;
			phase    <= pmsv_pkg::PH_IDLE;
			bit_cnt  <= 4'd0;
			shift    <= 8'h00;
			sel_plp  <= 1'b0;
			sda_low  <= 1'b0;
			rd_byte  <= 8'h00;
			ptr_pmic <= 8'h00;
			ptr_plp  <= 8'h00;
		end else begin
			scl_q <= LINK.scl;
			scl_p <= scl_q;
			sda_q <= LINK.sda;
			sda_p <= sda_q;
			if (start) begin
				phase   <= pmsv_pkg::PH_ADDR;
				bit_cnt <= 4'd0;
				sda_low <= 1'b0;
			end else if (stop) begin
				phase   <= pmsv_pkg::PH_IDLE;
				sda_low <= 1'b0;
			end else if (phase != pmsv_pkg::PH_IDLE) begin
				if (scl_rise) begin
					if (bit_cnt == 4'd8) begin
						bit_cnt <= 4'd0;
						if (phase == pmsv_pkg::PH_READ && sda_q)
							phase <= pmsv_pkg::PH_IDLE; // master refused more data
					end else begin
						shift   <= {shift[6:0], sda_q};
						bit_cnt <= bit_cnt + 4'd1;
					end
				end
				if (byte_done) begin
					case (phase)
						pmsv_pkg::PH_ADDR: begin
							if (hit_pmic || hit_plp) begin
								sel_plp <= hit_plp;
								sda_low <= 1'b1;
								phase   <= shift[0] ? pmsv_pkg::PH_READ : pmsv_pkg::PH_REG;
								rd_byte <= read_reg(hit_plp, hit_plp ? ptr_plp : ptr_pmic,
									sys_ctrl, mask, status, unlk_plp, unlk_pmic);
							end else begin
								phase <= pmsv_pkg::PH_IDLE;
							end
						end
						pmsv_pkg::PH_REG: begin
							if (sel_plp) ptr_plp <= shift;
							else ptr_pmic <= shift;
							sda_low <= 1'b1;
							phase   <= pmsv_pkg::PH_DATA;
						end
						pmsv_pkg::PH_DATA: sda_low <= 1'b1;
						default:           sda_low <= 1'b0;
					endcase
				end else if (scl_fall) begin
					if (phase == pmsv_pkg::PH_READ && bit_cnt < 4'd8)
						sda_low <= ~rd_byte[3'(4'd7 - bit_cnt)];
					else
						sda_low <= 1'b0;
				end
			end
		end
	end

	assign LINK.dev_sda_o    = 1'b0;
	assign LINK.dev_sda_oe_n = ~sda_low;

	// register writes behind the per-address locks
	always_ff @(posedge CORE_CLK_I) begin
		if (rst) begin
			sys_ctrl  <= pmsv_pkg::RST_SYS_CTRL;
			mask      <= pmsv_pkg::RST_MASK;
			unlk_pmic <= 1'b0;
			unlk_plp  <= 1'b0;
		end else if (pc_go || sr_go) begin
			sys_ctrl  <= pmsv_pkg::RST_SYS_CTRL;
			mask      <= pmsv_pkg::RST_MASK;
			unlk_pmic <= 1'b0;
		end else if (wr_stb) begin
			if (sel_plp) begin
				if (ptr_plp == pmsv_pkg::REG_KEY)
					unlk_plp <= shift == pmsv_pkg::KEY_UNLOCK;
			end else if (ptr_pmic == pmsv_pkg::REG_KEY) begin
				unlk_pmic <= shift == pmsv_pkg::KEY_UNLOCK;
			end else if (unlk_pmic) begin
				if (ptr_pmic == pmsv_pkg::REG_SYS_CTRL) sys_ctrl <= shift;
				if (ptr_pmic == pmsv_pkg::REG_MASK) mask <= shift;
			end
		end
	end

	// thermal levels with hysteresis
	assign next_th = {thermal_next(th[2], DIE_TEMP_I, pmsv_pkg::TEMP_ALL_OFF),
		thermal_next(th[1], DIE_TEMP_I, pmsv_pkg::TEMP_CONV_OFF),
		thermal_next(th[0], DIE_TEMP_I, pmsv_pkg::TEMP_ALERT)};

	// sticky status; a new event wins over the clear by read
	always_ff @(posedge CORE_CLK_I) begin
		if (rst) begin
			th     <= 3'b000;
			sticky <= 4'h0;
		end else begin
			th     <= next_th;
			sticky <= (rd_clr ? 4'h0 : sticky) | {wd_exp, next_th & ~th};
		end
	end

	// status reads back the live level so a persisting fault stays visible
	assign status = sticky | {1'b0, th};

	always_ff @(posedge CORE_CLK_I) begin
		if (rst) INTERRUPT_OUT_N_O <= 1'b1;
		else INTERRUPT_OUT_N_O <= ~|(status & ~mask[3:0]);
	end

	// watchdog
	assign wd_en  = sys_ctrl[pmsv_pkg::SYS_WD_SOFT_EN] | sys_ctrl[pmsv_pkg::SYS_WD_CYCLE_EN];
	assign wd_exp = wd_en && !kick && wd_cnt == pmsv_pkg::CNT_W'(WD_CYCLES - 1);
	assign pc_go  = (st == pmsv_pkg::SQ_ON) && (sys_ctrl[pmsv_pkg::SYS_MANUAL_CYCLE] ||
		(wd_exp && sys_ctrl[pmsv_pkg::SYS_WD_CYCLE_EN]));
	assign sr_go  = wd_exp && !sys_ctrl[pmsv_pkg::SYS_WD_CYCLE_EN];

	always_ff @(posedge CORE_CLK_I) begin
		if (rst || !wd_en || kick || wd_exp) wd_cnt <= '0;
		else wd_cnt <= wd_cnt + 1'b1;
	end

	// power sequencer
	always_ff @(posedge CORE_CLK_I) begin
		if (rst) begin
			st      <= pmsv_pkg::SQ_OFF;
			cyc_cnt <= '0;
		end else begin
			case (st)
				pmsv_pkg::SQ_OFF:   st <= pmsv_pkg::SQ_START;
				pmsv_pkg::SQ_START: st <= pmsv_pkg::SQ_ON;
				pmsv_pkg::SQ_ON: begin
					cyc_cnt <= '0;
					if (pc_go) st <= pmsv_pkg::SQ_CYCLE;
					else if (sys_ctrl[pmsv_pkg::SYS_POWER_OFF]) st <= pmsv_pkg::SQ_PWROFF;
				end
				pmsv_pkg::SQ_CYCLE: begin
					cyc_cnt <= cyc_cnt + 1'b1;
					if (cyc_cnt == pmsv_pkg::CNT_W'(PWR_CYCLE_CYCLES - 1))
						st <= pmsv_pkg::SQ_START;
				end
				pmsv_pkg::SQ_PWROFF:
					if (!sys_ctrl[pmsv_pkg::SYS_POWER_OFF]) st <= pmsv_pkg::SQ_START;
				default: st <= pmsv_pkg::SQ_OFF;
			endcase
		end
	end

	// regulator enables gated by thermal levels
	always_ff @(posedge CORE_CLK_I) begin
		if (rst) begin
			BUCK_EN_O    <= 4'h0;
			LDO_EN_O     <= 1'b0;
			BOOST_EN_O   <= 1'b0;
			SUPPLEMENT_O <= 1'b0;
			SOFT_START_O <= 1'b0;
			SOFT_RESET_O <= 1'b0;
		end else begin
			BUCK_EN_O    <= {4{st == pmsv_pkg::SQ_ON && !th[1] && !th[2]}};
			LDO_EN_O     <= st != pmsv_pkg::SQ_OFF && st != pmsv_pkg::SQ_PWROFF && !th[2];
			BOOST_EN_O   <= st != pmsv_pkg::SQ_OFF && st != pmsv_pkg::SQ_PWROFF && !th[1] &&
				!th[2];
			SUPPLEMENT_O <= pin_supp && GENERAL_PIN_FIVE_I;
			SOFT_START_O <= st == pmsv_pkg::SQ_START;
			SOFT_RESET_O <= sr_go;
		end
	end
endmodule : pmsv_device

// [rtl/pmsv_host.sv]
/*
 * Controller end: APB slave registers drive a serial bus master that writes
 * device registers or reads them through a pointer write and a read.
 * Assumes a single 40 MHz clock for APB and link; no clock stretching.
 */
`timescale 1ns/1ps
module pmsv_host (
	// clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// serial link
	pmsv_link_if.host        LINK
);
	logic                   wr_acc;
	logic                   go;
	logic [7:0]             reg_addr, wdata, rdata, rx;
	logic                   rd, plp, second, nack;
	pmsv_pkg::pmsv_hstate_t hst;
	logic [7:0]             div;
	logic                   tick;
	logic [1:0]             q;
	logic [3:0]             bit_i;
	logic [1:0]             byte_i;
	logic                   scl_low, sda_low;
	logic [7:0]             tx;
	logic                   recv, last;

	// byte to send in the current transaction
	function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic p,
		input logic r, input logic [7:0] ra, input logic [7:0] wd);
		case (idx)
			2'd0:    tx_byte = {p ? pmsv_pkg::ADDR_PLP : pmsv_pkg::ADDR_PMIC, r};
			2'd1:    tx_byte = ra;
			default: tx_byte = wd;
		endcase
	endfunction : tx_byte

	assign wr_acc    = PSEL_I && PENABLE_I && PWRITE_I;
	assign go        = wr_acc && PADDR_I == pmsv_pkg::HREG_CMD && PWDATA_I[pmsv_pkg::CMD_GO] &&
		hst == pmsv_pkg::HS_IDLE;
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = 1'b0;
	assign tx        = tx_byte(byte_i, plp, rd && second, reg_addr, wdata);
	assign recv      = rd && second && byte_i == 2'd1;
	assign last      = byte_i == ((rd && second) || rd ? 2'd1 : 2'd2);

	// apb read data
	always_comb begin
		case (PADDR_I)
			pmsv_pkg::HREG_ADDR:   PRDATA_O = {24'h000000, reg_addr};
			pmsv_pkg::HREG_WDATA:  PRDATA_O = {24'h000000, wdata};
			pmsv_pkg::HREG_STATUS: PRDATA_O = {30'h00000000, nack, hst != pmsv_pkg::HS_IDLE};
			pmsv_pkg::HREG_RDATA:  PRDATA_O = {24'h000000, rdata};
			default:               PRDATA_O = 32'h00000000;
		endcase
	end

	// apb writes of operands
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			reg_addr <= 8'h00;
			wdata    <= 8'h00;
		end else if (wr_acc) begin
			if (PADDR_I == pmsv_pkg::HREG_ADDR) reg_addr <= PWDATA_I[7:0];
			if (PADDR_I == pmsv_pkg::HREG_WDATA) wdata <= PWDATA_I[7:0];
		end
	end

	// quarter-bit tick
	assign tick = div == 8'(pmsv_pkg::QTR_CYCLES - 1);
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I || tick) div <= 8'h00;
		else div <= div + 8'h01;
	end

	// bus master sequencer
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			hst     <= pmsv_pkg::HS_IDLE;
			q       <= 2'd0;
			bit_i   <= 4'd0;
			byte_i  <= 2'd0;
			rd      <= 1'b0;
			plp     <= 1'b0;
			second  <= 1'b0;
			nack    <= 1'b0;
			rx      <= 8'h00;
			rdata   <= 8'h00;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
		end else if (go) begin
			hst    <= pmsv_pkg::HS_START;
			q      <= 2'd0;
			rd     <= PWDATA_I[pmsv_pkg::CMD_READ];
			plp    <= PWDATA_I[pmsv_pkg::CMD_PLP];
			second <= 1'b0;
			nack   <= 1'b0;
		end else if (tick) begin
			q <= q + 2'd1;
			case (hst)
				pmsv_pkg::HS_START: begin
					if (q == 2'd0) begin
						scl_low <= 1'b0;
						sda_low <= 1'b0;
					end else if (q == 2'd1) begin
						sda_low <= 1'b1;
					end else begin
						scl_low <= 1'b1;
						hst     <= pmsv_pkg::HS_BIT;
						q       <= 2'd0;
						bit_i   <= 4'd0;
						byte_i  <= 2'd0;
					end
				end
				pmsv_pkg::HS_BIT: begin
					if (q == 2'd0)
						sda_low <= bit_i < 4'd8 && !recv && !tx[3'(4'd7 - bit_i)];
					else if (q == 2'd1)
						scl_low <= 1'b0;
					else if (q == 2'd2) begin
						if (bit_i < 4'd8 && recv) rx <= {rx[6:0], LINK.sda};
						if (bit_i == 4'd8 && !recv && LINK.sda) nack <= 1'b1;
					end else begin
						scl_low <= 1'b1;
						bit_i   <= bit_i + 4'd1;
						if (bit_i == 4'd8) begin
							bit_i  <= 4'd0;
							byte_i <= byte_i + 2'd1;
							if (last || nack) begin
								hst <= pmsv_pkg::HS_STOP;
								q   <= 2'd0;
							end
						end
					end
				end
				pmsv_pkg::HS_STOP: begin
					if (q == 2'd0)
						sda_low <= 1'b1;
					else if (q == 2'd1)
						scl_low <= 1'b0;
					else begin
						sda_low <= 1'b0;
						q       <= 2'd0;
						if (rd && !second && !nack) begin
							second <= 1'b1;
							hst    <= pmsv_pkg::HS_START;
						end else begin
							hst <= pmsv_pkg::HS_IDLE;
							if (rd && !nack) rdata <= rx;
						end
					end
				end
				default: q <= 2'd0;
			endcase
		end
	end

	assign LINK.host_scl_o    = 1'b0;
	assign LINK.host_scl_oe_n = ~scl_low;
	assign LINK.host_sda_o    = 1'b0;
	assign LINK.host_sda_oe_n = ~sda_low;
endmodule : pmsv_host

// [sim/pmsv_checker.sv]
/* Checker: timed relations on supervisor outputs and the device data line.
   Assumes the bench instantiates it beside the link interface. */
`timescale 1ns/1ps
module pmsv_checker #(
	parameter int unsigned PWR_CYCLE_CYCLES = 200
) (
	// clock and reset
	input wire logic       CORE_CLK_I,
	input wire logic       RST_I,
	// supervisor pins
	input wire logic [7:0] DIE_TEMP_I,
	input wire logic [3:0] BUCK_EN_O,
	input wire logic       LDO_EN_O,
	input wire logic       BOOST_EN_O,
	input wire logic       SOFT_START_O,
	input wire logic       INTERRUPT_OUT_N_O,
	// link line
	input wire logic       dev_sda_oe_n
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	logic [15:0] off_cnt;
	// cycles with bucks down while ldo and boost stay up
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I || BUCK_EN_O != 4'h0 || !LDO_EN_O || !BOOST_EN_O) begin
			off_cnt <= 16'h0;
		end else begin
			off_cnt <= off_cnt + 16'h1;
		end
	end
	a_reset_all_off:
	assert property (disable iff (1'b0)
		RST_I |=> BUCK_EN_O == 4'h0 && !LDO_EN_O && INTERRUPT_OUT_N_O && dev_sda_oe_n)
		else $error("outputs active in reset");
	a_release_starts:
	assert property ($fell(RST_I) |-> ##[1:3] SOFT_START_O) else $error("no soft start");
	a_start_bucks_up:
	assert property (SOFT_START_O && DIE_TEMP_I <= 8'd120 |-> ##[1:2] BUCK_EN_O == 4'hf)
		else $error("bucks not started");
	a_alert_irq:
	assert property ((DIE_TEMP_I > 8'd120) [*4] |-> !INTERRUPT_OUT_N_O)
		else $error("alert without interrupt");
	a_hot_conv_off:
	assert property ((DIE_TEMP_I > 8'd145) [*4] |-> BUCK_EN_O == 4'h0 && !BOOST_EN_O)
		else $error("converters on while hot");
	a_hot_all_off:
	assert property ((DIE_TEMP_I > 8'd155) [*4] |-> !LDO_EN_O) else $error("ldo on while hot");
	a_hyst_hold:
	assert property (LDO_EN_O && !BOOST_EN_O && DIE_TEMP_I > 8'd130 |=> !BOOST_EN_O)
		else $error("boost back inside hysteresis");
	a_cycle_off_time:
	assert property ($rose(BUCK_EN_O[0]) && off_cnt > 16'd2 |->
		off_cnt >= PWR_CYCLE_CYCLES && off_cnt <= PWR_CYCLE_CYCLES + 4)
		else $error("power cycle off time wrong");
endmodule : pmsv_checker

// [sim/pmic_supervisor_control_bench.sv]
/* Bench: controller and supervisor joined by the link, driven over APB.
   Assumes the shared package and both ends are compiled first. */
`timescale 1ns/1ps
module pmic_supervisor_control_bench;
	localparam int unsigned WD  = 5000;
	localparam int unsigned PC  = 200;
	localparam logic [7:0]  SYS = pmsv_pkg::REG_SYS_CTRL;
	localparam logic [7:0]  KEY = pmsv_pkg::REG_KEY;
	localparam logic [7:0]  UNL = pmsv_pkg::KEY_UNLOCK;
	logic        clk = 1'b0, rst = 1'b1, supp = 1'b0, hrh = 1'b1, pin5 = 1'b0;
	logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0]  temp = 8'd25, paddr = 8'h00, rd;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0]  buck;
	logic        pready, ldo, boost, supo, sst, srst, irq_n;
	int          fail_count = 0, comparisons = 0, seed = 59329, n_srst = 0, k, t;
	logic [7:0]  thr [3] = '{8'd120, 8'd145, 8'd155};
	pmsv_link_if pmsv_link_if_inst ();
	pmsv_device #(.WD_CYCLES(WD), .PWR_CYCLE_CYCLES(PC)) pmsv_device_inst (
		.CORE_CLK_I(clk), .RST_I(rst), .FACTORY_PIN_SUPPLEMENT_I(supp),
		.FACTORY_HARD_RESET_HIGH_I(hrh), .GENERAL_PIN_FIVE_I(pin5), .DIE_TEMP_I(temp),
		.BUCK_EN_O(buck), .LDO_EN_O(ldo), .BOOST_EN_O(boost), .SUPPLEMENT_O(supo),
		.SOFT_START_O(sst), .SOFT_RESET_O(srst), .INTERRUPT_OUT_N_O(irq_n),
		.LINK(pmsv_link_if_inst));
	pmsv_host pmsv_host_inst (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(), .LINK(pmsv_link_if_inst));
	pmsv_checker #(.PWR_CYCLE_CYCLES(PC)) pmsv_checker_inst (.CORE_CLK_I(clk), .RST_I(rst),
		.DIE_TEMP_I(temp), .BUCK_EN_O(buck), .LDO_EN_O(ldo), .BOOST_EN_O(boost),
		.SOFT_START_O(sst), .INTERRUPT_OUT_N_O(irq_n),
		.dev_sda_oe_n(pmsv_link_if_inst.dev_sda_oe_n));
	// clock and soft reset pulse count
	always #12.5 clk = ~clk;
	always @(posedge clk) if (srst === 1'b1) n_srst <= n_srst + 1;
	// compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// a wait that ran out ends the run
	task automatic bound(input logic ok);
		chk("wait", ok, 1'b1);
		if (!ok) end_sim();
	endtask : bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		bound(n < 20);
		rd = prdata[7:0];
		psel <= 1'b0;
		pen  <= 1'b0;
		@(posedge clk);
	endtask : apb
	// one device access through the controller, result left in rd
	task automatic dev(input logic plp, input logic rdn, input logic [7:0] r, input logic [7:0] d);
		int n;
		apb(1'b1, pmsv_pkg::HREG_ADDR, {24'h0, r});
		apb(1'b1, pmsv_pkg::HREG_WDATA, {24'h0, d});
		apb(1'b1, pmsv_pkg::HREG_CMD, {29'h0, plp, rdn, 1'b1});
		n = 0;
		do begin
			apb(1'b0, pmsv_pkg::HREG_STATUS, 32'h0);
			n++;
		end while (rd[0] === 1'b1 && n < 3000);
		bound(n < 3000);
		chk("ack", rd[1], 1'b0);
		apb(1'b0, pmsv_pkg::HREG_RDATA, 32'h0);
	endtask : dev
	// expected {irq_n, boost, ldo} above threshold i
	function automatic logic [2:0] hot(input int i);
		return {1'b0, i < 1, i < 2};
	endfunction : hot
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		chk("up", {buck, ldo, boost, irq_n}, 7'h7f);
		for (int i = 0; i < 3; i++) begin
			k = $random(seed);
			temp <= thr[i] + 8'd1 + {5'h0, k[2:0]};
			repeat (8) @(posedge clk);
			chk("hot", {irq_n, boost, ldo}, hot(i));
			temp <= thr[i] - 8'd14;
			repeat (8) @(posedge clk);
			chk("warm", {irq_n, boost, ldo}, hot(i));
			temp <= thr[i] - 8'd15;
			repeat (8) @(posedge clk);
			chk("cool", {irq_n, boost, ldo}, hot(i >> 1));
			if (i == 0) begin
				dev(1'b0, 1'b1, pmsv_pkg::REG_STATUS, 8'h00);
				chk("irq read", {rd[0], irq_n}, 2'h3);
			end
		end
		temp <= 8'd25;
		repeat (20) @(posedge clk);
		chk("resumed", {buck, ldo, boost}, 6'h3f);
		dev(1'b0, 1'b0, SYS, 8'h02);
		chk("locked", {buck, ldo}, 5'h1f);
		dev(1'b1, 1'b0, KEY, UNL);
		dev(1'b0, 1'b0, SYS, 8'h02);
		dev(1'b0, 1'b1, KEY, 8'h00);
		chk("own lock", {rd, buck, ldo}, 13'h1f);
		k = $random(seed);
		dev(1'b0, 1'b0, KEY, UNL);
		dev(1'b0, 1'b0, KEY, {1'b0, k[6:0]});
		dev(1'b0, 1'b0, SYS, 8'h02);
		chk("relocked", {buck, ldo}, 5'h1f);
		dev(1'b0, 1'b0, KEY, UNL);
		// thermal sticky bits are pending: mask them all, then unmask the alert only
		dev(1'b0, 1'b0, pmsv_pkg::REG_MASK, 8'h07);
		chk("masked", irq_n, 1'b1);
		dev(1'b0, 1'b0, pmsv_pkg::REG_MASK, 8'h06);
		chk("unmasked", irq_n, 1'b0);
		dev(1'b0, 1'b0, SYS, 8'h02);
		repeat (400) @(posedge clk);
		chk("off", {buck, ldo, boost}, 6'h00);
		dev(1'b0, 1'b0, SYS, 8'h00);
		repeat (8) @(posedge clk);
		chk("restart", {buck, ldo, boost}, 6'h3f);
		dev(1'b0, 1'b0, SYS, 8'h01);
		chk("cycling", {buck, ldo, boost}, 6'h03);
		for (t = 0; buck !== 4'hf && t < 2 * PC; t++) @(posedge clk);
		bound(t < 2 * PC);
		dev(1'b0, 1'b0, SYS, 8'h02);
		chk("volatile", {27'h0, buck, ldo}, 32'h1f);
		chk("no soft reset", n_srst, 32'h0);
		dev(1'b0, 1'b0, KEY, UNL);
		dev(1'b0, 1'b0, SYS, 8'h04);
		dev(1'b0, 1'b1, KEY, 8'h00);
		chk("fed", n_srst, 32'h0);
		for (t = 0; n_srst == 0 && t < WD; t++) @(posedge clk);
		chk("expiry", {n_srst == 1, t > 1000}, 2'h3);
		dev(1'b0, 1'b0, KEY, UNL);
		dev(1'b0, 1'b0, SYS, 8'h0c);
		for (t = 0; buck !== 4'h0 && t < WD; t++) @(posedge clk);
		chk("wd cycle", {n_srst == 1, ldo, buck}, 6'h30);
		repeat (300) @(posedge clk);
		for (int i = 0; i < 2; i++) begin
			hrh  <= i[0];
			pin5 <= !i[0];
			rst  <= 1'b1;
			repeat (3) @(posedge clk);
			rst <= 1'b0;
			repeat (8) @(posedge clk);
			pin5 <= i[0];
			repeat (4) @(posedge clk);
			chk("held", {buck, ldo, irq_n}, 6'h01);
			pin5 <= !i[0];
			repeat (8) @(posedge clk);
			chk("released", {buck, ldo, boost}, 6'h3f);
		end
		supp <= 1'b1;
		rst  <= 1'b1;
		repeat (3) @(posedge clk);
		rst  <= 1'b0;
		pin5 <= 1'b1;
		repeat (8) @(posedge clk);
		chk("supplement", {supo, ldo, buck}, 6'h3f);
		end_sim();
	end
endmodule : pmic_supervisor_control_bench
